// [core/cmol_pkg.sv]
// constants, register map and lookup tables of the conveyor muting
// override block; assumes one 250 MHz clock and a 1 ms execution cycle
package cmol_pkg;
  // clock and execution cycle
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned EXEC_US       = 1000;
  localparam int unsigned EXEC_CYC_DEF  = CLK_MHZ * EXEC_US;
  localparam int unsigned EXEC_MS       = EXEC_US / 1000;
  // durations in ms and in execution ticks
  localparam int unsigned OVR_MIN_A_MS  = 100;
  localparam int unsigned OVR_MIN_B_MS  = 350;
  localparam int unsigned OVR_MAX_MS    = 3000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BELT_EXT_MS   = 5000;
  localparam logic [11:0] OVR_MIN_A_TK  = 12'(OVR_MIN_A_MS / EXEC_MS);
  localparam logic [11:0] OVR_MIN_B_TK  = 12'(OVR_MIN_B_MS / EXEC_MS);
  localparam logic [11:0] OVR_MAX_TK    = 12'(OVR_MAX_MS / EXEC_MS);
  localparam logic [8:0]  BLINK_TK      = 9'(BLINK_HALF_MS / EXEC_MS);
  localparam logic [22:0] BELT_EXT_TK   = 23'(BELT_EXT_MS / EXEC_MS);
  // total muting time choices, in ticks, and permitted override cycles
  localparam int unsigned TMT_N         = 10;
  localparam logic [3:0]  TMT_UNLIM     = 4'h9;
  localparam logic [22:0] TMT_TK [TMT_N] = '{
    23'h001388, 23'h002710, 23'h004e20, 23'h007530, 23'h00ea60,
    23'h0493e0, 23'h0dbba0, 23'h1b7740, 23'h36ee80, 23'h000000};
  localparam logic [8:0]  OVR_LIM [TMT_N] = '{
    9'h168, 9'h168, 9'h0b4, 9'h078, 9'h03c,
    9'h00c, 9'h005, 9'h005, 9'h005, 9'h005};
  // register map
  localparam logic [11:0] ADDR_CFG      = 12'h000;
  localparam logic [11:0] ADDR_STAT     = 12'h004;
  localparam logic [11:0] ADDR_CMD      = 12'h008;
  localparam int unsigned CFG_MIN_BIT   = 0;
  localparam int unsigned CFG_TMT_LSB   = 1;
  localparam int unsigned CFG_BELT_BIT  = 5;
  localparam logic [5:0]  CFG_RST       = 6'h20;
  localparam int unsigned STAT_CNT_LSB  = 16;
  localparam int unsigned CMD_RUN_BIT   = 0;
  typedef logic [8:0] cmol_cnt_t;
endpackage

// [core/cmol_tick_if.sv]
// execution tick, blink and override-valid signals shared by the
// block's own modules; all on pclk
`timescale 1ns/1ps
interface cmol_tick_if;
  logic tick;
  logic blink;
  logic ovr_ok;
  logic min_sel;
  modport gen  (output tick, output blink);
  modport pchk (input tick, input min_sel, output ovr_ok);
  modport core (input tick, input blink, input ovr_ok, output min_sel);
endinterface

// [core/cmol_tick_gen.sv]
// execution-cycle divider and 2 Hz blink source
// assumes pclk at the package rate
`timescale 1ns/1ps
module cmol_tick_gen #(
  parameter int unsigned EXEC_CYC = cmol_pkg::EXEC_CYC_DEF
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // tick and blink
  cmol_tick_if.gen  tif
);
  logic [31:0] div_ff;
  logic [8:0]  blk_ff;
  logic        tick_ff;
  logic        blink_ff;

  assign tif.tick  = tick_ff;
  assign tif.blink = blink_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_ff == 32'(EXEC_CYC - 1));
      div_ff  <= (div_ff == 32'(EXEC_CYC - 1)) ? 32'h0 : div_ff + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_ff   <= 9'h0;
      blink_ff <= 1'b0;
    end else if (tick_ff) begin
      if (blk_ff == cmol_pkg::BLINK_TK - 9'h1) begin
        blk_ff   <= 9'h0;
        blink_ff <= ~blink_ff;
      end else begin
        blk_ff <= blk_ff + 9'h1;
      end
    end
  end

  a_tick_one: assert property (@(posedge pclk) disable iff (!presetn)
    tick_ff |=> !tick_ff) else $error("tick longer than one cycle");
endmodule // cmol_tick_gen

// [core/cmol_pulse_chk.sv]
// measures the high time of the synchronised override level
// in execution ticks and flags a valid pulse on its falling edge
`timescale 1ns/1ps
module cmol_pulse_chk (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // synchronised override level
  input  wire logic ovr_lvl,
  // tick in, valid pulse out
  cmol_tick_if.pchk tif
);
  logic [11:0] hi_ff;
  logic        lvl_ff;
  logic        ok_ff;
  logic [11:0] min_tk;

  assign min_tk     = tif.min_sel ? cmol_pkg::OVR_MIN_B_TK
                                  : cmol_pkg::OVR_MIN_A_TK;
  assign tif.ovr_ok = ok_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_ff  <= 12'h0;
      lvl_ff <= 1'b0;
      ok_ff  <= 1'b0;
    end else begin
      lvl_ff <= ovr_lvl;
      ok_ff  <= lvl_ff && !ovr_lvl && hi_ff >= min_tk
                && hi_ff <= cmol_pkg::OVR_MAX_TK;
      if (!ovr_lvl)
        hi_ff <= 12'h0;
      else if (tif.tick && hi_ff <= cmol_pkg::OVR_MAX_TK)
        hi_ff <= hi_ff + 12'h1;
    end
  end

  a_pulse_width: assert property (
    @(posedge pclk) disable iff (!presetn)
    ok_ff |-> $past(hi_ff) >= min_tk && $past(hi_ff) <= cmol_pkg::OVR_MAX_TK)
    else $error("override accepted outside width window");
endmodule // cmol_pulse_chk

// [core/cmol_core.sv]
// conveyor muting override, belt stop and output status logic
// sensors, curtain, override and belt arrive as pins; the sequencer
// supplies its verdicts on pclk and reads the hold and tick outputs
`timescale 1ns/1ps
module cmol_core #(
  parameter int unsigned EXEC_CYC = cmol_pkg::EXEC_CYC_DEF
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pins
  input  wire logic [3:0]  sens_pin,
  input  wire logic        curtain_safe_outputs,
  input  wire logic        ovr_pin,
  input  wire logic        belt_pin,
  // sequencer verdicts
  input  wire logic        seq_mute_valid,
  input  wire logic        seq_error,
  input  wire logic [3:0]  seq_fault_mask,
  // sequencer controls
  output logic             mon_hold,
  output logic             sim_tick,
  output logic             gap_tick,
  // outputs
  output logic             mute_status,
  output logic             mute_lamp,
  output logic             mute_error,
  output logic             release_out,
  output logic             ovr_required
);
  typedef enum logic [2:0] {
    F_IDLE = 3'b001,
    F_WHI  = 3'b010,
    F_WLO  = 3'b100
  } cmol_fst_e;

  cmol_tick_if tif ();

  logic [6:0]        s1_ff, s2_ff;
  logic [5:0]        cfg_ff;
  logic              arm_ff, run_cmd;
  cmol_fst_e         fst_ff;
  logic [3:0]        fmask_ff;
  logic              req_on_ff, shot_ff, pend_ff, ovr_act_ff;
  logic              err_ff, mute_act_ff, belt_prev_ff, ext_ff;
  logic [22:0]       tmt_ff;
  cmol_pkg::cmol_cnt_t cnt_ff;
  logic              stat_ff, lamp_ff, rel_ff, oreq_ff;
  logic              hold_ff, stk_ff, gtk_ff;
  logic              rdy_ff, err_bus_ff;
  logic [31:0]       rd_ff;

  logic [3:0]  sens;
  logic        curtain, belt, any_sens, clr_cond, req_cond, run;
  logic        ovr_start, cyc_done, tmt_exp, fault_now;
  logic [3:0]  tmt_idx;
  logic [8:0]  lim;
  logic [22:0] tmt_lim;
  logic        acc, hit;
  logic [31:0] rdata;

  cmol_tick_gen #(.EXEC_CYC(EXEC_CYC)) cmol_tick_gen_i (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif.gen)
  );

  cmol_pulse_chk cmol_pulse_chk_i (
    .pclk    (pclk),
    .presetn (presetn),
    .ovr_lvl (s2_ff[5]),
    .tif     (tif.pchk)
  );

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 7'h0;
      s2_ff <= 7'h0;
    end else begin
      s1_ff <= {belt_pin, ovr_pin, curtain_safe_outputs, sens_pin};
      s2_ff <= s1_ff;
    end
  end

  assign sens     = s2_ff[3:0];
  assign curtain  = s2_ff[4];
  assign belt     = s2_ff[6];
  assign any_sens = |sens;
  assign clr_cond = !any_sens && curtain;
  assign req_cond = !stat_ff && any_sens && !curtain && !rel_ff;
  assign run      = belt || !cfg_ff[cmol_pkg::CFG_BELT_BIT];
  assign tif.min_sel = cfg_ff[cmol_pkg::CFG_MIN_BIT];
  assign tmt_idx  = (cfg_ff[cmol_pkg::CFG_TMT_LSB +: 4] > cmol_pkg::TMT_UNLIM)
                    ? cmol_pkg::TMT_UNLIM : cfg_ff[cmol_pkg::CFG_TMT_LSB +: 4];
  assign lim      = cmol_pkg::OVR_LIM[tmt_idx];
  assign tmt_lim  = cmol_pkg::TMT_TK[tmt_idx]
                    + (ext_ff ? cmol_pkg::BELT_EXT_TK : 23'h0);
  assign tmt_exp  = (tmt_idx != cmol_pkg::TMT_UNLIM) && tmt_ff >= tmt_lim;
  assign ovr_start = tif.tick && req_on_ff && (pend_ff || tif.ovr_ok)
                     && cnt_ff <= lim;
  assign cyc_done = tif.tick && mute_act_ff && !seq_mute_valid && !err_ff;
  assign fault_now = (fst_ff == F_IDLE) && (|seq_fault_mask);

  // apb access
  assign acc     = psel && penable && rdy_ff;
  assign hit     = paddr == cmol_pkg::ADDR_CFG || paddr == cmol_pkg::ADDR_STAT
                   || paddr == cmol_pkg::ADDR_CMD;
  assign run_cmd = acc && pwrite && paddr == cmol_pkg::ADDR_CMD
                   && pstrb[0] && pwdata[cmol_pkg::CMD_RUN_BIT];

  always_comb begin
    rdata = 32'h0;
    unique case (paddr)
      cmol_pkg::ADDR_CFG:  rdata = {26'h0, cfg_ff};
      cmol_pkg::ADDR_STAT: rdata = {7'h0, cnt_ff, 10'h0, ovr_act_ff,
                                    oreq_ff, rel_ff, err_ff, lamp_ff,
                                    stat_ff};
      default:             rdata = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ff     <= 1'b0;
      rd_ff      <= 32'h0;
      err_bus_ff <= 1'b0;
    end else begin
      rdy_ff     <= psel && penable && !rdy_ff;
      rd_ff      <= (psel && penable && !rdy_ff && !pwrite) ? rdata : 32'h0;
      err_bus_ff <= psel && penable && !rdy_ff && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cfg_ff <= cmol_pkg::CFG_RST;
    else if (acc && pwrite && paddr == cmol_pkg::ADDR_CFG && pstrb[0])
      cfg_ff <= pwdata[5:0];
  end

  // sensor fault tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fst_ff   <= F_IDLE;
      fmask_ff <= 4'h0;
    end else if (tif.tick) begin
      unique case (fst_ff)
        F_IDLE: if (|seq_fault_mask) begin
          fst_ff   <= F_WHI;
          fmask_ff <= seq_fault_mask;
        end
        F_WHI: if ((sens & fmask_ff) == fmask_ff) fst_ff <= F_WLO;
        F_WLO: if ((sens & fmask_ff) == 4'h0) fst_ff <= F_IDLE;
        default: fst_ff <= F_IDLE;
      endcase
    end
  end

  // override request and cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_on_ff  <= 1'b0;
      shot_ff    <= 1'b0;
      ovr_act_ff <= 1'b0;
    end else if (tif.tick) begin
      req_on_ff <= req_cond && fst_ff == F_IDLE && !fault_now;
      shot_ff   <= req_cond && fault_now;
      if (ovr_start)
        ovr_act_ff <= 1'b1;
      else if (clr_cond || seq_mute_valid)
        ovr_act_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pend_ff <= 1'b0;
    else if (tif.ovr_ok)
      pend_ff <= req_on_ff;
    else if (tif.tick)
      pend_ff <= 1'b0;
  end

  // override cycle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 9'h0;
      arm_ff <= 1'b1;
    end else begin
      if (cyc_done && arm_ff)
        cnt_ff <= 9'h0;
      else if (tif.tick && req_cond && fst_ff == F_IDLE && !fault_now
               && !req_on_ff && cnt_ff != 9'h1ff)
        cnt_ff <= cnt_ff + 9'h1;
      if (run_cmd)
        arm_ff <= 1'b1;
      else if (cyc_done)
        arm_ff <= 1'b0;
    end
  end

  // muting error, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_ff <= 1'b0;
    else if (tif.tick) begin
      if ((seq_error && !ovr_act_ff) || tmt_exp)
        err_ff <= 1'b1;
      else if (clr_cond || ovr_start)
        err_ff <= 1'b0;
    end
  end

  // total muting timer with belt pause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_act_ff  <= 1'b0;
      belt_prev_ff <= 1'b1;
      ext_ff       <= 1'b0;
      tmt_ff       <= 23'h0;
    end else if (tif.tick) begin
      mute_act_ff  <= seq_mute_valid;
      belt_prev_ff <= run;
      if (!mute_act_ff && !ovr_act_ff) begin
        tmt_ff <= 23'h0;
        ext_ff <= 1'b0;
      end else begin
        if (run && !tmt_exp)
          tmt_ff <= tmt_ff + 23'h1;
        if (run && !belt_prev_ff)
          ext_ff <= 1'b1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= 1'b0;
      lamp_ff <= 1'b0;
      rel_ff  <= 1'b0;
      oreq_ff <= 1'b0;
      hold_ff <= 1'b0;
      stk_ff  <= 1'b0;
      gtk_ff  <= 1'b0;
    end else begin
      stat_ff <= (mute_act_ff || ovr_act_ff) && !err_ff;
      lamp_ff <= ((mute_act_ff || ovr_act_ff) && !err_ff) || ovr_act_ff
                 || (req_on_ff && tif.blink);
      rel_ff  <= (mute_act_ff || ovr_act_ff || curtain) && !err_ff;
      oreq_ff <= (req_on_ff && tif.blink) || shot_ff;
      hold_ff <= ovr_act_ff;
      stk_ff  <= tif.tick && run;
      gtk_ff  <= tif.tick;
    end
  end

  assign pready       = rdy_ff;
  assign prdata       = rd_ff;
  assign pslverr      = err_bus_ff;
  assign mon_hold     = hold_ff;
  assign sim_tick     = stk_ff;
  assign gap_tick     = gtk_ff;
  assign mute_status  = stat_ff;
  assign mute_lamp    = lamp_ff;
  assign mute_error   = err_ff;
  assign release_out  = rel_ff;
  assign ovr_required = oreq_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_status_err: assert property (err_ff |=> !stat_ff)
    else $error("status high with error");
  a_release_err: assert property (err_ff |=> !rel_ff)
    else $error("release high with error");
  a_lamp_follow: assert property (stat_ff |-> lamp_ff)
    else $error("lamp low while status high");
  a_cnt_clear: assert property (cyc_done && arm_ff |=> cnt_ff == 9'h0)
    else $error("count not cleared after valid cycle");
  a_timer_freeze: assert property (
    tif.tick && !run && (mute_act_ff || ovr_act_ff) |=> $stable(tmt_ff))
    else $error("muting timer ran during belt stop");
  a_hold_ovr: assert property (ovr_act_ff |=> hold_ff)
    else $error("monitoring not held in override");
  a_err_clear: assert property ($fell(err_ff) |->
    $past(clr_cond) || $past(ovr_start))
    else $error("error cleared without free field");
  a_cnt_step: assert property (
    $rose(req_on_ff) && $past(cnt_ff) != 9'h1ff
    |-> cnt_ff == $past(cnt_ff) + 9'h1)
    else $error("count not stepped at request start");
  a_shot_once: assert property (shot_ff && tif.tick |=> !shot_ff)
    else $error("fault request pulse longer than one tick");
endmodule // cmol_core

// [testbench/cmol_field_model.sv]
// field side of the muting block: sensors, light curtain, button, belt
// assumes the bench steers it on pclk; the button lasts press_len cycles
`timescale 1ns/1ps
module cmol_field_model (
  // clock
  input  wire logic        pclk,
  // steering from the bench
  input  wire logic [3:0]  obj_at,
  input  wire logic        obj_in_field,
  input  wire logic        belt_run,
  input  wire logic        press_go,
  input  wire logic [15:0] press_len,
  // pins
  output logic [3:0]       sens_pin,
  output logic             curtain_safe_outputs,
  output logic             ovr_pin,
  output logic             belt_pin
);
  logic [15:0] press_ff = 16'h0000;

  always_ff @(posedge pclk) begin
    sens_pin             <= obj_at;
    curtain_safe_outputs <= !obj_in_field;
    // low while the conveyor stands, high while it runs
    belt_pin             <= belt_run;
  end

  always_ff @(posedge pclk) begin
    if (press_go) begin
      press_ff <= press_len;
    end else if (press_ff != 16'h0000) begin
      press_ff <= press_ff - 16'h0001;
    end
  end

  assign ovr_pin = (press_ff != 16'h0000);
endmodule // cmol_field_model

// [testbench/tb_conveyor_muting_override_logic.sv]
// self-checking bench for the conveyor muting override block
// assumes cmol_core with a 4-cycle execution tick and the field model
`timescale 1ns/1ps
module tb_conveyor_muting_override_logic;
  localparam int unsigned EC = 4;
  typedef struct {logic [32:0] v; logic [32:0] m;} cmol_exp_s;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic [3:0]  sens_pin, obj_at = 4'h0, seq_fault_mask = 4'h0;
  logic        curtain_safe_outputs, ovr_pin, belt_pin;
  logic        obj_in_field = 1'b0, belt_run = 1'b1, press_go = 1'b0;
  logic [15:0] press_len = 16'h0000;
  logic        seq_mute_valid = 1'b0, seq_error = 1'b0;
  logic        mon_hold, sim_tick, gap_tick, mute_status, mute_lamp;
  logic        mute_error, release_out, ovr_required;
  logic [7:0]  rnd = 8'h55;
  int          n_errors = 0, n_tests = 0, cyc = 0, h, ns, ng;
  int          lens [3] = '{200, 3100, 400};
  cmol_exp_s   q [$];
  cmol_exp_s   x;

  cmol_field_model cmol_field_model_i (.pclk(pclk), .obj_at(obj_at),
    .obj_in_field(obj_in_field), .belt_run(belt_run),
    .press_go(press_go), .press_len(press_len), .sens_pin(sens_pin),
    .curtain_safe_outputs(curtain_safe_outputs), .ovr_pin(ovr_pin),
    .belt_pin(belt_pin));

  cmol_core #(.EXEC_CYC(EC)) cmol_core_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sens_pin(sens_pin),
    .curtain_safe_outputs(curtain_safe_outputs), .ovr_pin(ovr_pin),
    .belt_pin(belt_pin), .seq_mute_valid(seq_mute_valid),
    .seq_error(seq_error), .seq_fault_mask(seq_fault_mask),
    .mon_hold(mon_hold),
    .sim_tick(sim_tick), .gap_tick(gap_tick), .mute_status(mute_status),
    .mute_lamp(mute_lamp), .mute_error(mute_error),
    .release_out(release_out), .ovr_required(ovr_required));

  initial begin
    forever #2 pclk = ~pclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one apb transfer; a read leaves its expectation in the queue
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    if (!w) q.push_back('{e, m});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat(input logic [31:0] e, input logic [31:0] m);
    apb(cmol_pkg::ADDR_STAT, 1'b0, 32'h0, {1'b0, e}, {1'b1, m});
  endtask

  task automatic ticks(input int n);
    repeat (n * EC) @(posedge pclk);
  endtask

  task automatic press(input int t);
    @(posedge pclk);
    press_go  <= 1'b1;
    press_len <= 16'(t * EC);
    @(posedge pclk);
    press_go  <= 1'b0;
    repeat ((t + 8) * EC) @(posedge pclk);
  endtask

  // cycles for which ovr_required stays high from now
  task automatic high_time(output int n);
    n = 0;
    while (ovr_required === 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic wait_req(input logic v);
    int k;
    k = 0;
    while (ovr_required !== v && k < 3000) begin
      @(posedge pclk);
      k++;
    end
  endtask

  // scoreboard side: compare each read answer with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      x = q.pop_front();
      check({pslverr, prdata} & x.m, x.v);
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(cmol_pkg::ADDR_CFG, 1'b0, 32'h0, 33'h20, 33'h3f);
    apb(12'h00c, 1'b0, 32'h0, 33'h100000000, 33'h1ffffffff);
    rnd = lfsr(rnd);
    apb(cmol_pkg::ADDR_STAT, 1'b1, {4{rnd}}, 33'h0, 33'h0);
    ticks(10);
    stat(32'h08, 32'h3f);
    apb(cmol_pkg::ADDR_CFG, 1'b1, 32'h21, 33'h0, 33'h0);
    // object left in the field with some sensors active
    rnd = lfsr(rnd);
    @(posedge pclk);
    obj_at       <= rnd[3:0] | 4'h1;
    obj_in_field <= 1'b1;
    wait_req(1'b1);
    ticks(4);
    stat(32'h00010000, 32'h01ff002d);
    // blink phases after the first are whole
    wait_req(1'b0);
    wait_req(1'b1);
    high_time(h);
    check(33'(h), 33'(250 * EC));
    // too short for the 350 tick minimum, too long, then valid
    for (int i = 0; i < 3; i++) begin
      press(lens[i]);
      stat((i == 2) ? 32'h2b : 32'h00, (i == 2) ? 32'h2f : 32'h28);
    end
    check({32'h0, mon_hold}, 33'h1);
    @(posedge pclk);
    belt_run <= 1'b0;
    ticks(4);
    ns = 0;
    ng = 0;
    repeat (40) begin
      @(posedge pclk);
      ns += int'(sim_tick !== 1'b0);
      ng += int'(gap_tick === 1'b1);
    end
    check(33'(ns), 33'h0);
    check({32'h0, ng != 0}, 33'h1);
    belt_run     <= 1'b1;
    obj_at       <= 4'h0;
    obj_in_field <= 1'b0;
    ticks(10);
    stat(32'h08, 32'h2f);
    @(posedge pclk);
    obj_at         <= 4'h3;
    seq_mute_valid <= 1'b1;
    ticks(10);
    stat(32'h0b, 32'h0f);
    @(posedge pclk);
    obj_at         <= 4'h0;
    seq_mute_valid <= 1'b0;
    ticks(10);
    stat(32'h0, 32'h01ff0000);
    @(posedge pclk);
    obj_at       <= 4'h1;
    obj_in_field <= 1'b1;
    seq_error    <= 1'b1;
    ticks(5);
    seq_error    <= 1'b0;
    ticks(5);
    stat(32'h04, 32'h0d);
    @(posedge pclk);
    obj_at <= 4'h0;
    ticks(10);
    stat(32'h04, 32'h04);
    @(posedge pclk);
    obj_in_field <= 1'b0;
    ticks(10);
    stat(32'h08, 32'h0c);
    // fault shot, suppressed request, then resume after high-low
    @(posedge pclk);
    obj_at       <= 4'h3;
    obj_in_field <= 1'b1;
    wait_req(1'b1);
    wait_req(1'b0);
    @(posedge pclk);
    seq_fault_mask <= 4'h2;
    wait_req(1'b1);
    high_time(h);
    check(33'(h), 33'(EC));
    seq_fault_mask <= 4'h0;
    ticks(10);
    stat(32'h00, 32'h1f);
    @(posedge pclk);
    obj_at <= 4'h1;
    wait_req(1'b1);
    check({32'h0, ovr_required}, 33'h1);
    @(posedge pclk);
    obj_at       <= 4'h0;
    obj_in_field <= 1'b0;
    ticks(10);
    // count kept until a run write to the CMD register re-arms the clear
    for (int i = 0; i < 2; i++) begin
      if (i == 1) apb(cmol_pkg::ADDR_CMD, 1'b1, 32'h1, 33'h0, 33'h0);
      @(posedge pclk);
      seq_mute_valid <= 1'b1;
      ticks(5);
      seq_mute_valid <= 1'b0;
      ticks(5);
      stat((i == 0) ? 32'h00030000 : 32'h0, 32'h01ff0000);
    end
    ticks(2);
    summarize();
  end
endmodule // tb_conveyor_muting_override_logic
